// >>> bci_pkg.sv
// Shared constants and types for the battery controller serial link
package bci_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Spikes shorter than this never reach the protocol logic
  localparam int unsigned SPIKE_NS      = 50;
  localparam int unsigned SPIKE_CYC     =
    (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  SPIKE_LIM     = 3'(SPIKE_CYC - 1);
  // Half serial clock period; 2 x 1300 ns keeps the link under 400 kHz
  localparam int unsigned HALF_NS       = 1300;
  localparam int unsigned HALF_CYC      =
    (HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  HALF_LIM      = 8'(HALF_CYC - 1);
  localparam logic [7:0]  HALF_MID      = 8'(HALF_CYC / 2);

  // ****************************************
  // Protocol constants
  // ****************************************
  localparam logic [4:0]  ADDR_FIXED    = 5'h17;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT   = 4'h7;
  localparam logic        DIR_WRITE     = 1'b0;
  localparam logic        DIR_READ      = 1'b1;
  localparam logic [1:0]  IDX_PTR       = 2'h1;
  localparam logic [1:0]  IDX_LAST_WR   = 2'h2;
  localparam logic [1:0]  IDX_LAST_RD   = 2'h3;
  localparam logic [7:0]  BYTE_IDLE     = 8'hff;
  localparam int unsigned LINE_SCL      = 0;
  localparam int unsigned LINE_SDA      = 1;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [2:0] {
    DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_MACK, DS_WAIT
  } bci_dev_st_t;

  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} bci_kind_t;

  typedef enum logic [3:0] {
    HS_IDLE, HS_START, HS_LOW, HS_HIGH, HS_RS_LOW, HS_RS_HIGH,
    HS_STOP_LOW, HS_STOP_HIGH, HS_STOP_END
  } bci_host_st_t;

endpackage : bci_pkg

// >>> bci_link_if.sv
// Two-wire link between host and device, with open-drain resolution
`timescale 1ns/1ps
`default_nettype none
interface bci_link_if;
  logic scl;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda;

  // Pull-up wins unless one end pulls low
  assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));

  modport dev (
    input  scl,
    input  sda,
    output sda_dev_o,
    output sda_dev_oe
  );

  modport host (
    output scl,
    input  sda,
    output sda_host_o,
    output sda_host_oe
  );
endinterface : bci_link_if
`default_nettype wire

// >>> bci_dev.sv
// Device end: two-wire slave with spike filter and register port
//
// Notes on behaviour
// - Address is 10111 plus two strap bits
// - Strap pin high gives one, low zero
// - Address LSB zero writes, one reads
// - Sample data while clock high, change low
// - Data falling with clock high is START
// - Data rising with clock high is STOP
// - Host sends address byte MSB first
// - Matching address gets data held low
// - Host releases data for acknowledge, else STOP
// - Pointer byte follows address, is acknowledged
// - One write data byte, acknowledged after
// - Pointer selects register written by data
// - Idle data line left released high
// - Host clock no faster than 400 kHz
// - Ignore spikes shorter than 50 ns
// - Read: write pointer, restart, read address
// - Hardware reset input resets serial logic
`timescale 1ns/1ps
`default_nettype none
module bci_dev
  import bci_pkg::*;
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  // Pins
  input  wire logic       i_hw_reset_n,
  input  wire logic       i_addr_strap_low,
  input  wire logic       i_addr_strap_high,
  bci_link_if.dev         link,
  // Register port
  input  wire logic [7:0] i_rd_data,
  output logic      [7:0] o_reg_ptr,
  output logic      [7:0] o_wr_data,
  output logic            o_wr_stb
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0]  line_s1;
  logic [1:0]  line_s2;
  logic [1:0]  strap_s1;
  logic [1:0]  strap_s2;
  logic        hwr_s1;
  logic        hwr_s2;
  logic        srst;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      line_s1  <= 2'h3;
      line_s2  <= 2'h3;
      hwr_s1   <= 1'b0;
      hwr_s2   <= 1'b0;
    end else begin
      line_s1  <= {link.sda, link.scl};
      line_s2  <= line_s1;
      hwr_s1   <= i_hw_reset_n;
      hwr_s2   <= hwr_s1;
    end
  end

  assign srst = !i_nrst || !hwr_s2;

  // Straps are taken while in reset, so a live pin cannot shift the address;
  // their synchroniser runs through reset so that it holds the pins by then
  logic [1:0] strap;
  always_ff @(posedge i_core_clk) begin
    strap_s1 <= {i_addr_strap_high, i_addr_strap_low};
    strap_s2 <= strap_s1;
    if (srst) begin
      strap <= strap_s2;
    end
  end

  // ****************************************
  // Spike filters
  // ****************************************
  logic [1:0] line_f;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_filt
      logic [2:0] fcnt;
      always_ff @(posedge i_core_clk) begin
        if (srst) begin
          fcnt      <= 3'h0;
          line_f[g] <= 1'b1;
        end else if (line_s2[g] == line_f[g]) begin
          fcnt <= 3'h0;
        end else if (fcnt == SPIKE_LIM) begin
          fcnt      <= 3'h0;
          line_f[g] <= line_s2[g];
        end else begin
          fcnt <= fcnt + 3'h1;
        end
      end
    end
  endgenerate

  // ****************************************
  // Line events
  // ****************************************
  logic [1:0] line_d;
  always_ff @(posedge i_core_clk) begin
    if (srst) begin
      line_d <= 2'h3;
    end else begin
      line_d <= line_f;
    end
  end

  wire scl_f     = line_f[LINE_SCL];
  wire sda_f     = line_f[LINE_SDA];
  wire scl_rise  = scl_f && !line_d[LINE_SCL];
  wire scl_fall  = !scl_f && line_d[LINE_SCL];
  wire scl_hold  = scl_f && line_d[LINE_SCL];
  wire start_det = scl_hold && line_d[LINE_SDA] && !sda_f;
  wire stop_det  = scl_hold && !line_d[LINE_SDA] && sda_f;

  // ****************************************
  // Protocol engine
  // ****************************************
  bci_dev_st_t st;
  bci_dev_st_t next_st;
  bci_kind_t   kind;
  bci_kind_t   next_kind;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [7:0]  sh;
  logic [7:0]  next_sh;
  logic        oe;
  logic        next_oe;
  logic        direction_bit;
  logic        next_direction_bit;
  logic [7:0]  next_ptr;
  logic [7:0]  next_wdata;
  logic        next_wstb;
  logic        mack;
  logic        next_mack;

  wire addr_hit = sh[7:1] == {ADDR_FIXED, strap};

  always_comb begin
    next_st            = st;
    next_kind          = kind;
    next_cnt           = cnt;
    next_sh            = sh;
    next_oe            = oe;
    next_direction_bit = direction_bit;
    next_ptr           = o_reg_ptr;
    next_wdata         = o_wr_data;
    next_wstb          = 1'b0;
    next_mack          = mack;
    if (start_det) begin
      next_st   = DS_RX;
      next_kind = K_ADDR;
      next_cnt  = 4'h0;
      next_oe   = 1'b0;
    end else if (stop_det) begin
      next_st = DS_IDLE;
      next_oe = 1'b0;
    end else begin
      unique case (st)
        DS_IDLE, DS_WAIT: begin
          next_oe = 1'b0;
        end
        DS_RX: begin
          if (scl_rise && cnt != BYTE_BITS) begin
            next_sh  = {sh[6:0], sda_f};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == BYTE_BITS) begin
            next_st = DS_ACK;
            next_oe = 1'b1;
            unique case (kind)
              K_ADDR: begin
                if (addr_hit) begin
                  next_direction_bit = sh[0];
                end else begin
                  next_st = DS_WAIT;
                  next_oe = 1'b0;
                end
              end
              K_PTR:  next_ptr   = sh;
              K_DATA: next_wdata = sh;
            endcase
          end
        end
        DS_ACK: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            next_oe  = 1'b0;
            next_st  = DS_RX;
            if (kind == K_ADDR && direction_bit == DIR_READ) begin
              next_st = DS_TX;
              next_sh = i_rd_data;
              next_oe = !i_rd_data[7];
            end else if (kind == K_ADDR) begin
              next_kind = K_PTR;
            end else if (kind == K_PTR) begin
              next_kind = K_DATA;
            end else begin
              next_st   = DS_WAIT;
              next_wstb = 1'b1;
            end
          end
        end
        DS_TX: begin
          if (scl_fall) begin
            if (cnt == LAST_TX_BIT) begin
              next_st = DS_MACK;
              next_oe = 1'b0;
            end else begin
              next_sh  = {sh[6:0], 1'b0};
              next_cnt = cnt + 4'h1;
              next_oe  = !sh[6];
            end
          end
        end
        DS_MACK: begin
          if (scl_rise) begin
            next_mack = sda_f;
          end else if (scl_fall) begin
            // Host acknowledged: send the same register again
            if (!mack) begin
              next_st  = DS_TX;
              next_cnt = 4'h0;
              next_sh  = i_rd_data;
              next_oe  = !i_rd_data[7];
            end else begin
              next_st = DS_WAIT;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (srst) begin
      st            <= DS_IDLE;
      kind          <= K_ADDR;
      cnt           <= 4'h0;
      sh            <= 8'h00;
      oe            <= 1'b0;
      direction_bit <= DIR_WRITE;
      o_reg_ptr     <= 8'h00;
      o_wr_data     <= 8'h00;
      o_wr_stb      <= 1'b0;
      mack          <= 1'b1;
    end else begin
      st            <= next_st;
      kind          <= next_kind;
      cnt           <= next_cnt;
      sh            <= next_sh;
      oe            <= next_oe;
      direction_bit <= next_direction_bit;
      o_reg_ptr     <= next_ptr;
      o_wr_data     <= next_wdata;
      o_wr_stb      <= next_wstb;
      mack          <= next_mack;
    end
  end

  // Open drain: the output level is always low, only the enable moves
  assign link.sda_dev_o  = 1'b0;
  assign link.sda_dev_oe = oe;

endmodule : bci_dev
`default_nettype wire

// >>> bci_host.sv
// Host end: two-wire master that writes or reads one register
`timescale 1ns/1ps
`default_nettype none
module bci_host
  import bci_pkg::*;
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  // Link
  bci_link_if.host        link,
  // Request
  input  wire logic       i_go,
  input  wire logic       i_rd,
  input  wire logic [6:0] i_dev_addr,
  input  wire logic [7:0] i_ptr,
  input  wire logic [7:0] i_wdata,
  // Answer
  output logic            o_busy,
  output logic            o_done,
  output logic            o_nack,
  output logic      [7:0] o_rdata
);

  // ****************************************
  // Data line synchroniser and tick
  // ****************************************
  logic sda_s1;
  logic sda_s2;
  logic [7:0] tcnt;
  bci_host_st_t st;

  wire tick = tcnt == HALF_LIM;
  wire mid  = tcnt == HALF_MID;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      tcnt   <= 8'h00;
    end else begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      tcnt   <= (st == HS_IDLE || tick) ? 8'h00 : tcnt + 8'h01;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  bci_host_st_t next_st;
  logic         scl;
  logic         next_scl;
  logic         oe;
  logic         next_oe;
  logic [3:0]   slot;
  logic [3:0]   next_slot;
  logic [1:0]   idx;
  logic [1:0]   next_idx;
  logic [7:0]   sh;
  logic [7:0]   next_sh;
  logic         rd;
  logic [6:0]   addr;
  logic [7:0]   ptr;
  logic [7:0]   wdata;
  logic [7:0]   next_rdata;
  logic         next_nack;
  logic         next_done;

  wire rx_phase  = idx == IDX_LAST_RD;
  wire last_byte = rd ? rx_phase : (idx == IDX_LAST_WR);
  wire [7:0] after_ptr = rd ? {addr, DIR_READ} : {addr, DIR_WRITE};
  wire [7:0] after_addr = ptr;
  wire [7:0] next_byte = (idx == 2'h0)  ? after_addr :
                         (idx == IDX_PTR) ? (rd ? after_ptr : wdata) :
                         BYTE_IDLE;
  wire drive_low = (slot != BYTE_BITS) && !rx_phase && !sh[7];

  always_comb begin
    next_st    = st;
    next_scl   = scl;
    next_oe    = oe;
    next_slot  = slot;
    next_idx   = idx;
    next_sh    = sh;
    next_rdata = o_rdata;
    next_nack  = o_nack;
    next_done  = 1'b0;
    unique case (st)
      HS_IDLE: begin
        if (i_go) begin
          next_st   = HS_START;
          next_oe   = 1'b1;
          next_idx  = 2'h0;
          next_nack = 1'b0;
          next_sh   = {i_dev_addr, DIR_WRITE};
        end
      end
      HS_START: if (tick) begin
        next_st   = HS_LOW;
        next_scl  = 1'b0;
        next_slot = 4'h0;
      end
      HS_LOW: begin
        if (mid) begin
          next_oe = drive_low;
        end
        if (tick) begin
          next_st  = HS_HIGH;
          next_scl = 1'b1;
        end
      end
      HS_HIGH: if (tick) begin
        next_scl = 1'b0;
        next_st  = HS_LOW;
        if (slot != BYTE_BITS) begin
          next_sh   = {sh[6:0], sda_s2};
          next_slot = slot + 4'h1;
        end else if (!rx_phase && sda_s2) begin
          next_nack = 1'b1;
          next_st   = HS_STOP_LOW;
        end else if (last_byte) begin
          next_st = HS_STOP_LOW;
          if (rx_phase) begin
            next_rdata = sh;
          end
        end else begin
          next_idx  = idx + 2'h1;
          next_slot = 4'h0;
          next_sh   = next_byte;
          if (rd && idx == IDX_PTR) begin
            next_st = HS_RS_LOW;
          end
        end
      end
      HS_RS_LOW: begin
        if (mid) begin
          next_oe = 1'b0;
        end
        if (tick) begin
          next_st  = HS_RS_HIGH;
          next_scl = 1'b1;
        end
      end
      HS_RS_HIGH: if (tick) begin
        next_st = HS_START;
        next_oe = 1'b1;
      end
      HS_STOP_LOW: begin
        if (mid) begin
          next_oe = 1'b1;
        end
        if (tick) begin
          next_st  = HS_STOP_HIGH;
          next_scl = 1'b1;
        end
      end
      HS_STOP_HIGH: if (tick) begin
        next_st = HS_STOP_END;
        next_oe = 1'b0;
      end
      HS_STOP_END: if (tick) begin
        // One half period of bus free time before the next start
        next_st   = HS_IDLE;
        next_done = 1'b1;
      end
      default: next_st = HS_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      st      <= HS_IDLE;
      scl     <= 1'b1;
      oe      <= 1'b0;
      slot    <= 4'h0;
      idx     <= 2'h0;
      sh      <= 8'h00;
      o_rdata <= 8'h00;
      o_nack  <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      st      <= next_st;
      scl     <= next_scl;
      oe      <= next_oe;
      slot    <= next_slot;
      idx     <= next_idx;
      sh      <= next_sh;
      o_rdata <= next_rdata;
      o_nack  <= next_nack;
      o_done  <= next_done;
    end
  end

  // Request fields held for the whole transfer
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      rd    <= DIR_WRITE;
      addr  <= 7'h00;
      ptr   <= 8'h00;
      wdata <= 8'h00;
    end else if (st == HS_IDLE && i_go) begin
      rd    <= i_rd;
      addr  <= i_dev_addr;
      ptr   <= i_ptr;
      wdata <= i_wdata;
    end
  end

  assign o_busy           = st != HS_IDLE;
  assign link.scl         = scl;
  assign link.sda_host_o  = 1'b0;
  assign link.sda_host_oe = oe;

endmodule : bci_host
`default_nettype wire

// >>> bci_link_chk.sv
// Concurrent checks on the two-wire link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module bci_link_chk (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  // Link signals
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sda_dev_o,
  input  wire logic sda_dev_oe
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic        scl_q;
  logic        sda_q;
  logic [7:0]  run;
  logic [3:0]  bitn;
  logic [11:0] since;
  // Conditions need the clock high on both samples
  wire         start_c    = scl & scl_q & sda_q & ~sda;
  wire         stop_c     = scl & scl_q & ~sda_q & sda;
  wire         scl_edge   = scl ^ scl_q;
  wire         scl_rise   = scl & ~scl_q;
  wire  [7:0]  next_run   = (run == 8'hff) ? run : run + 8'h01;
  wire  [3:0]  bit_inc    = (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
  wire  [3:0]  next_bitn  = start_c ? 4'h0 : (scl_rise ? bit_inc : bitn);
  wire  [11:0] since_inc  = (since == 12'hfff) ? since : since + 12'h001;
  wire  [11:0] next_since = start_c ? 12'h000 : since_inc;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      run   <= 8'h00;
      bitn  <= 4'h0;
      since <= 12'hfff;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      run   <= scl_edge ? 8'h00 : next_run;
      bitn  <= next_bitn;
      since <= next_since;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  a_dev_only_low: assert property (sda_dev_oe |-> !sda_dev_o)
    else $error("device drives data line high");
  a_dev_change_low: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_ack_held: assert property (
    $rose(sda_dev_oe) |-> sda_dev_oe throughout ##[100:140] $rose(scl))
    else $error("device low not held into clock pulse");
  a_addr_quiet: assert property (since < 12'd2100 |-> !sda_dev_oe)
    else $error("device drove line during address byte");
  a_stop_idle: assert property (stop_c |=> !sda_dev_oe [*8])
    else $error("device not idle after stop");
  a_idle_high: assert property (stop_c |-> ##1 (sda && scl) [*8])
    else $error("data line not left high after stop");
  a_scl_low_min: assert property ($rose(scl) |-> run >= 8'd125)
    else $error("clock low phase too short");
  a_scl_high_min: assert property ($fell(scl) |-> run >= 8'd125)
    else $error("clock high phase too short");
  a_nack_stop: assert property (
    $rose(scl) && bitn == 4'h8 && sda |-> ##[1:600] stop_c)
    else $error("no stop after missing acknowledge");
endmodule : bci_link_chk
`default_nettype wire

// >>> bci_tb_top.sv
// Self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module battery_ctrl_i2c_slave_tb_top;
  logic       clk;
  logic       nrst;
  logic       hw_n;
  logic [1:0] strap;
  logic       go;
  logic       rd;
  logic [6:0] addr;
  logic [7:0] ptr;
  logic [7:0] wdata;
  logic [7:0] rd_data;
  logic [7:0] reg_ptr;
  logic [7:0] wr_data;
  logic       wr_stb;
  logic       busy;
  logic       done;
  logic       nack;
  logic [7:0] rdata;
  int         n_errors;
  int         n_checks;
  int         n_stb;
  int         cyc;

  // ****************************************
  // Link, ends and checker
  // ****************************************
  bci_link_if u_bci_link_if ();

  // Register file stand-in: contents follow the selected pointer
  assign rd_data = reg_ptr ^ 8'h3c;

  bci_dev u_bci_dev (
    .i_core_clk(clk), .i_nrst(nrst), .i_hw_reset_n(hw_n),
    .i_addr_strap_low(strap[0]), .i_addr_strap_high(strap[1]),
    .link(u_bci_link_if.dev), .i_rd_data(rd_data),
    .o_reg_ptr(reg_ptr), .o_wr_data(wr_data), .o_wr_stb(wr_stb));

  bci_host u_bci_host (
    .i_core_clk(clk), .i_nrst(nrst), .link(u_bci_link_if.host),
    .i_go(go), .i_rd(rd), .i_dev_addr(addr), .i_ptr(ptr),
    .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_nack(nack),
    .o_rdata(rdata));

  bci_link_chk u_bci_link_chk (
    .i_core_clk(clk), .i_nrst(nrst), .scl(u_bci_link_if.scl),
    .sda(u_bci_link_if.sda), .sda_dev_o(u_bci_link_if.sda_dev_o),
    .sda_dev_oe(u_bci_link_if.sda_dev_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Sampled off the launching edge so the strobe is settled
  always @(negedge clk) begin
    cyc++;
    if (wr_stb === 1'b1) n_stb++;
    if (cyc == 90000) begin
      n_errors++;
      $display("[ERR] %0t run too long", $time);
      results();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Straps are only taken while reset is low
  task automatic reset_to(input logic [1:0] s);
    @(negedge clk);
    nrst  = 1'b0;
    strap = s;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (12) @(negedge clk);
  endtask : reset_to

  task automatic launch(input logic r, input logic [6:0] a,
                        input logic [7:0] p, input logic [7:0] w);
    @(negedge clk);
    go    = 1'b1;
    rd    = r;
    addr  = a;
    ptr   = p;
    wdata = w;
    @(negedge clk);
    go = 1'b0;
    chk({7'h00, busy}, 8'h01);
  endtask : launch

  task automatic wait_done;
    int k;
    k = 0;
    while (done !== 1'b1 && k < 12000) begin
      @(negedge clk);
      k++;
    end
    chk({7'h00, done}, 8'h01);
    chk({7'h00, busy}, 8'h00);
  endtask : wait_done

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_straps;
    int b;
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      reset_to(s);
      b = n_stb;
      launch(1'b0, {5'h17, s}, 8'h40 | 8'(i), 8'ha0 + 8'(i));
      wait_done();
      chk({7'h00, nack}, 8'h00);
      chk(8'(n_stb - b), 8'h01);
      chk(reg_ptr, 8'h40 | 8'(i));
      chk(wr_data, 8'ha0 + 8'(i));
      launch(1'b0, {5'h17, ~s}, 8'h11, 8'h22);
      wait_done();
      chk({7'h00, nack}, 8'h01);
      chk(8'(n_stb - b), 8'h01);
      chk(reg_ptr, 8'h40 | 8'(i));
    end
  endtask : t_straps

  task automatic t_read;
    int b;
    logic [7:0] p;
    b = n_stb;
    for (int i = 0; i < 2; i++) begin
      p = (i == 0) ? 8'h05 : 8'hff;
      launch(1'b1, {5'h17, strap}, p, 8'h00);
      wait_done();
      chk({7'h00, nack}, 8'h00);
      chk(rdata, p ^ 8'h3c);
      chk(reg_ptr, p);
    end
    chk(8'(n_stb - b), 8'h00);
    launch(1'b0, {5'h07, strap}, 8'h66, 8'h77);
    wait_done();
    chk({7'h00, nack}, 8'h01);
  endtask : t_read

  // Pin reset in mid-pointer: device drops out, host sees no ack
  task automatic t_hwrst;
    int b;
    b = n_stb;
    launch(1'b0, {5'h17, strap}, 8'h33, 8'h44);
    repeat (3000) @(negedge clk);
    hw_n = 1'b0;
    repeat (60) @(negedge clk);
    hw_n = 1'b1;
    wait_done();
    chk({7'h00, nack}, 8'h01);
    chk(reg_ptr, 8'h00);
    chk(wr_data, 8'h00);
    chk(8'(n_stb - b), 8'h00);
    repeat (12) @(negedge clk);
    launch(1'b0, {5'h17, strap}, 8'h33, 8'h44);
    wait_done();
    chk({7'h00, nack}, 8'h00);
    chk(wr_data, 8'h44);
  endtask : t_hwrst

  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  initial begin
    nrst     = 1'b0;
    hw_n     = 1'b1;
    strap    = 2'h0;
    go       = 1'b0;
    rd       = 1'b0;
    addr     = 7'h00;
    ptr      = 8'h00;
    wdata    = 8'h00;
    n_errors = 0;
    n_checks = 0;
    n_stb    = 0;
    cyc      = 0;
    t_straps();
    t_read();
    t_hwrst();
    results();
  end
endmodule : battery_ctrl_i2c_slave_tb_top
`default_nettype wire
